/* File: hw/timr_sequencer.v */
`timescale 1ns/1ps
`include "timr_regs.vh"
// Overview of operation
// - Long range: fine interval from start to next cal edge, then coarse count.
// - Long range: stop restarts fine unit; next cal edge ends second interval.
// - Calibration run measures one and two cal periods, stores both values.
// - Coarse counter is 16 bits of cal periods, one count per cal edge.
// - Long range uses stop 1 only, up to four hits.
// - Long range results reference start only, no stop differences.
// - Long range next stop accepted once two cal periods and at least 25 ns have both passed.
// - Combined mode: one channel, four hits, stop 2 ignored.
// - Combined mode in long range captures at most three hits.
// - Regulated mode: no start, two channels, four hits, stop differences.
// - Regulated mode span over half range is invalid.
// - Regulated mode exposes lock flag; falls back and returns automatically.
// - Regulated mode works with combined mode, not in long range.
// - Control 0 bit 7 starts calibration; cleared by device when done.
// - Autocalibration starts once selected hits seen on each channel in use.
// - Pre-ALU converts selected raw values without a clock.
// - Main ALU passes, corrects, calibrates, multiplies by 24-bit factor.
// - 16-bit main ALU on adjustable internal tick, about 1.7 us total at the default divider.
// - Eight 16-bit results; uncalibrated uses one, calibrated uses two.
// - Results fill 0 to 7 then wrap.
// - Result reads have no side effects.
// - Seven control, four value registers written; results, status, proposal read.
// - Control 0 bit 4 selects long range.
// - Control and value registers are write-only.
module timr_sequencer
#(
    parameter FINE_W  = 15,
    parameter ALU_DIV = 8'h04
)
(
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        startPin,
    input  wire        stop1Pin,
    input  wire        stop2Pin,
    input  wire        calClkPin,
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWr,
    input  wire        regRd,
    input  wire        pllLocked,
    input  wire [7:0]  pllProposal,
    output reg  [7:0]  regRdData_r,
    output reg  [7:0]  loopAdjust_r,
    output reg         regulatedActive_r
);
    localparam [FINE_W-1:0] FINE_MAX = {FINE_W{1'b1}};
    // Stop spacing: 25 ns rounded up to cycles, and two cal edges counted; both must pass
    localparam [7:0] GAP_CYC = (`TIMR_STOP_GAP_NS + `TIMR_CLK_NS - 1) / `TIMR_CLK_NS;
    localparam [2:0] S_IDLE = 3'h0, S_FINE1 = 3'h1, S_COARSE = 3'h2,
                     S_FINE2 = 3'h3, S_CAL1 = 3'h4, S_CAL2 = 3'h5, S_CALSYNC = 3'h6;
    localparam [2:0] A_IDLE = 3'h0, A_CAL = 3'h1, A_MUL = 3'h2, A_STORE = 3'h3;

    // Synchronised pins
    wire startS, stop1S, stop2S, calS;
    reg  startD_r, stop1D_r, stop2D_r, calD_r;
    wire startEdge = startS & ~startD_r;
    wire stop1Edge = stop1S & ~stop1D_r;
    wire stop2Edge = stop2S & ~stop2D_r;
    wire calEdge   = calS & ~calD_r;

    timr_sync uSyncSta (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(startPin),
                        .pinSync_r(startS));
    timr_sync uSyncSp1 (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(stop1Pin),
                        .pinSync_r(stop1S));
    timr_sync uSyncSp2 (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(stop2Pin),
                        .pinSync_r(stop2S));
    timr_sync uSyncCal (.clk_sys(clk_sys), .reset_n(reset_n), .pinIn(calClkPin),
                        .pinSync_r(calS));

    // Previous synced levels; reset to the idle low so no false edge follows reset
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            {startD_r, stop1D_r, stop2D_r, calD_r} <= 4'h0;
        else
            {startD_r, stop1D_r, stop2D_r, calD_r} <= {startS, stop1S, stop2S, calS};
    end

    // Write-only registers
    reg [7:0]  ctrl_r [0:6];
    reg [23:0] mulFactor_r;
    wire longRange = ctrl_r[0][`TIMR_C0_LONG];
    wire combined  = ctrl_r[1][`TIMR_C1_COMB];
    // Regulated mode never runs in the long range
    wire regulated = ctrl_r[1][`TIMR_C1_REGRES] & ~longRange;
    wire [2:0] hitLimit = (combined & longRange) ? 3'h3 : 3'h4;

    // Measurement state
    reg [2:0]        mState_r;
    reg [FINE_W-1:0] fineCnt_r;
    reg [15:0]       coarse_r;
    reg [15:0]       raw_r [0:3];
    reg [2:0]        hits1_r, hits2_r;
    reg [7:0]        gapCnt_r;
    reg [1:0]        gapEdges_r;
    reg [15:0]       cal1_r, cal2_r;
    reg              calBusy_r, calDone_r, spanErr_r, timeout_r;
    reg [15:0]       span_r;
    reg              spanRun_r;
    wire stop2Used = ~combined & ~longRange;
    wire gapOk     = (gapCnt_r >= GAP_CYC) && (gapEdges_r == 2'h2);
    wire calReq    = ctrl_r[0][`TIMR_C0_CALRUN] & ~calDone_r;     // Bit clears a cycle late
    wire autoHit   = ctrl_r[0][`TIMR_C0_AUTOCAL] &&
                     hits1_r >= ctrl_r[3][2:0] &&
                     (!stop2Used || hits2_r >= ctrl_r[3][2:0]) && ctrl_r[3][2:0] != 3'h0;
    integer i;

    // Measurement sequencer
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mState_r <= S_IDLE;
            fineCnt_r <= {FINE_W{1'b0}};
            coarse_r <= 16'h0000;
            hits1_r <= 3'h0;
            hits2_r <= 3'h0;
            gapCnt_r <= 8'h00;
            gapEdges_r <= 2'h0;
            cal1_r <= 16'h0000;
            cal2_r <= 16'h0000;
            calBusy_r <= 1'b0;
            calDone_r <= 1'b0;
            spanErr_r <= 1'b0;
            timeout_r <= 1'b0;
            span_r <= 16'h0000;
            spanRun_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
                raw_r[i] <= 16'h0000;
        end
        else
        begin
            calDone_r <= 1'b0;
            if (fineCnt_r != FINE_MAX)
                fineCnt_r <= fineCnt_r + 1'b1;
            if (gapCnt_r != 8'hff)
                gapCnt_r <= gapCnt_r + 1'b1;
            if (calEdge && gapEdges_r != 2'h2)
                gapEdges_r <= gapEdges_r + 1'b1;
            // Span watch from first stop in regulated mode
            if (spanRun_r)
            begin
                span_r <= span_r + 1'b1;
                if (span_r >= `TIMR_SPAN_LSB)
                    spanErr_r <= 1'b1;
            end
            case (mState_r)
            S_IDLE:
            begin
                if (calReq || autoHit)
                begin
                    mState_r <= S_CALSYNC;
                    calBusy_r <= 1'b1;
                    fineCnt_r <= {FINE_W{1'b0}};
                    hits1_r <= 3'h0;
                    hits2_r <= 3'h0;
                end
                else if (longRange && startEdge)
                begin
                    mState_r <= S_FINE1;
                    fineCnt_r <= {FINE_W{1'b0}};
                    hits1_r <= 3'h0;
                    timeout_r <= 1'b0;
                end
                else if (!longRange)
                begin
                    if (startEdge && !regulated)
                    begin
                        fineCnt_r <= {FINE_W{1'b0}};               // Start unused when regulated
                        hits1_r <= 3'h0;
                        hits2_r <= 3'h0;
                    end
                    if (regulated && (stop1Edge || stop2Edge) && !spanRun_r)
                    begin
                        spanRun_r <= 1'b1;
                        span_r <= 16'h0000;
                        spanErr_r <= 1'b0;
                    end
                    if (stop1Edge && hits1_r < hitLimit)
                    begin
                        raw_r[hits1_r[1:0]] <= {1'b0, fineCnt_r};
                        hits1_r <= hits1_r + 1'b1;
                    end
                    // Second input ignored when channels combine
                    if (stop2Used && stop2Edge && hits2_r < hitLimit)
                        hits2_r <= hits2_r + 1'b1;
                end
            end
            S_FINE1:
            if (calEdge)
            begin
                raw_r[0] <= {1'b0, fineCnt_r};                     // first fine interval
                coarse_r <= 16'h0000;
                mState_r <= S_COARSE;
            end
            S_COARSE:
            begin
                if (calEdge)
                begin
                    coarse_r <= coarse_r + 1'b1;
                    if (coarse_r == 16'hffff)
                    begin
                        timeout_r <= 1'b1;
                        mState_r <= S_IDLE;
                    end
                end
                // Only stop 1, spaced by the double-pulse gap
                if (stop1Edge && hits1_r < hitLimit && (hits1_r == 3'h0 || gapOk))
                begin
                    fineCnt_r <= {FINE_W{1'b0}};
                    mState_r <= S_FINE2;
                end
            end
            S_FINE2:
            if (calEdge)
            begin
                // Each hit stores coarse and second fine interval, start-referenced
                raw_r[hits1_r[1:0]] <= {1'b0, fineCnt_r} + coarse_r;
                hits1_r <= hits1_r + 1'b1;
                gapCnt_r <= 8'h00;
                gapEdges_r <= 2'h0;
                mState_r <= S_COARSE;
            end
            // Periods are timed from a cal edge, not from the request
            S_CALSYNC:
            if (calEdge)
            begin
                fineCnt_r <= {FINE_W{1'b0}};
                mState_r <= S_CAL1;
            end
            S_CAL1:
            if (calEdge)
            begin
                cal1_r <= {1'b0, fineCnt_r};                       // one period
                mState_r <= S_CAL2;
            end
            S_CAL2:
            if (calEdge)
            begin
                cal2_r <= {1'b0, fineCnt_r};                       // two periods
                calBusy_r <= 1'b0;
                calDone_r <= 1'b1;
                mState_r <= S_IDLE;
            end
            default:
                mState_r <= S_IDLE;
            endcase
            if (!regulated)
                spanRun_r <= 1'b0;
        end
    end

    // Pre-ALU
    wire [15:0] valA, valB;
    timr_prealu uPre (.rawFlat({raw_r[3], raw_r[2], raw_r[1], raw_r[0]}),
                      .selA(ctrl_r[2][2:0]), .selB(ctrl_r[2][6:4]),
                      .halfRes(ctrl_r[6][0]), .valA(valA), .valB(valB));

    // ALU internal tick divider, adjustable through control 6
    reg [7:0] aluDiv_r;
    wire [7:0] aluDivLoad = ctrl_r[6][7:4] == 4'h0 ? ALU_DIV : {4'h0, ctrl_r[6][7:4]};
    wire aluTick = (aluDiv_r == 8'h00);
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            aluDiv_r <= 8'h00;
        else
            aluDiv_r <= aluTick ? aluDivLoad : aluDiv_r - 1'b1;
    end

    // Main ALU and result ring
    reg [2:0]  aState_r;
    reg [4:0]  aStep_r;
    reg [15:0] diff_r;
    reg [31:0] work_r;
    reg        aluGo_r;
    reg [15:0] result_r [0:7];
    reg [2:0]  wrPtr_r;
    reg        twoWords_r;
    wire [39:0] prod = work_r[31:16] * mulFactor_r;

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aState_r <= A_IDLE;
            aStep_r <= 5'h00;
            diff_r <= 16'h0000;
            work_r <= 32'h00000000;
            wrPtr_r <= 3'h0;
            twoWords_r <= 1'b0;
            for (i = 0; i < 8; i = i + 1)
                result_r[i] <= 16'h0000;
        end
        else
        case (aState_r)
        A_IDLE:
        // Wait for any calibration run to finish
        if (aluGo_r && !calBusy_r && mState_r != S_CAL1)
        begin
            // Subtraction of B from A; long range ignores B
            diff_r <= longRange ? valA : valA - valB;
            aStep_r <= 5'h00;
            if (ctrl_r[0][`TIMR_C0_DOCAL] || longRange)
                aState_r <= A_CAL;
            else
            begin
                work_r <= {longRange ? valA : valA - valB, 16'h0000};
                twoWords_r <= 1'b0;                                // pass through
                aState_r <= A_STORE;
            end
        end
        A_CAL:
        if (aluTick)
        begin
            aStep_r <= aStep_r + 1'b1;
            if (aStep_r == `TIMR_CAL_STEPS)
            begin
                // Calibrated value: diff * period / (cal2 - cal1), 16.16 fixed
                work_r <= (cal2_r == cal1_r) ? 32'hffffffff :
                          {diff_r, 16'h0000} / {16'h0000, cal2_r - cal1_r};
                twoWords_r <= 1'b1;
                aStep_r <= 5'h00;
                aState_r <= ctrl_r[0][`TIMR_C0_DOMUL] ? A_MUL : A_STORE;
            end
        end
        A_MUL:
        if (aluTick)
        begin
            aStep_r <= aStep_r + 1'b1;
            if (aStep_r == `TIMR_MUL_STEPS)
            begin
                work_r <= {prod[38:23], work_r[15:0]};              // top factor bit weighs one
                aState_r <= A_STORE;
            end
        end
        A_STORE:
        begin
            result_r[wrPtr_r] <= work_r[31:16];
            if (twoWords_r)
                result_r[wrPtr_r + 3'h1] <= work_r[15:0];
            wrPtr_r <= wrPtr_r + (twoWords_r ? 3'h2 : 3'h1);       // wraps 7 to 0
            aState_r <= A_IDLE;
        end
        default:
            aState_r <= A_IDLE;
        endcase
    end

    // Register writes; the device clears the calibration bit itself
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < 7; i = i + 1)
                ctrl_r[i] <= `TIMR_RESET8;
            mulFactor_r <= 24'h800000;
            loopAdjust_r <= `TIMR_RESET8;
            aluGo_r <= 1'b0;
        end
        else
        begin
            if (aState_r != A_IDLE)
                aluGo_r <= 1'b0;
            if (regWr && regAddr <= `TIMR_A_CTRL6)
                ctrl_r[regAddr[2:0]] <= regWrData;
            if (regWr && regAddr == `TIMR_A_CTRL2)
                aluGo_r <= 1'b1;                                   // writing the instruction launches ALU
            if (regWr && regAddr == `TIMR_A_MUL0)
                mulFactor_r[7:0] <= regWrData;
            if (regWr && regAddr == `TIMR_A_MUL1)
                mulFactor_r[15:8] <= regWrData;
            if (regWr && regAddr == `TIMR_A_MUL2)
                mulFactor_r[23:16] <= regWrData;
            if (regWr && regAddr == `TIMR_A_LOOPADJ)
                loopAdjust_r <= regWrData;
            // Clear after run; a new set written in the same cycle wins
            if (calDone_r && !(regWr && regAddr == `TIMR_A_CTRL0 && regWrData[7]))
                ctrl_r[0][`TIMR_C0_CALRUN] <= 1'b0;
        end
    end

    // Read port: results by address, low/high byte by control 6 bit 1, status, proposal
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regRdData_r <= 8'h00;
            regulatedActive_r <= 1'b0;
        end
        else
        begin
            // Falls back while unlocked, returns on relock
            regulatedActive_r <= regulated & pllLocked;
            if (regRd)
            begin
                // Pure reads; nothing advances
                if (regAddr < `TIMR_A_STAT0)
                    regRdData_r <= ctrl_r[6][1] ? result_r[regAddr[2:0]][15:8]
                                               : result_r[regAddr[2:0]][7:0];
                else if (regAddr == `TIMR_A_STAT0)
                    regRdData_r <= {calBusy_r, aState_r != A_IDLE, wrPtr_r, hits1_r};
                else if (regAddr == `TIMR_A_STAT1)
                    regRdData_r <= {regulated & pllLocked, spanErr_r, timeout_r,
                                    2'h0, hits2_r};
                else if (regAddr == `TIMR_A_PROPOSAL)
                    regRdData_r <= pllProposal;
                else
                    regRdData_r <= 8'h00;
            end
            else
                regRdData_r <= 8'h00;
        end
    end
endmodule // timr_sequencer

/* File: hw/timr_regs.vh */
`ifndef TIMR_REGS_VH
`define TIMR_REGS_VH
// Write map (write-only): control 0..6, multiplier 7..9, loop adjust 10
`define TIMR_A_CTRL0     4'h0
`define TIMR_A_CTRL1     4'h1
`define TIMR_A_CTRL2     4'h2
`define TIMR_A_CTRL6     4'h6
`define TIMR_A_MUL0      4'h7
`define TIMR_A_MUL1      4'h8
`define TIMR_A_MUL2      4'h9
`define TIMR_A_LOOPADJ   4'ha
// Read map: results 0..7, status 8..9, adjust proposal 10
`define TIMR_A_STAT0     4'h8
`define TIMR_A_STAT1     4'h9
`define TIMR_A_PROPOSAL  4'ha
// Control 0 fields
`define TIMR_C0_CALRUN   7
`define TIMR_C0_DOCAL    6
`define TIMR_C0_DOMUL    5
`define TIMR_C0_LONG     4
`define TIMR_C0_AUTOCAL  3
// Control 1 fields
`define TIMR_C1_REGRES   7
`define TIMR_C1_COMB     6
// Control 2: hit select nibbles, control 3 low bits: hit count
`define TIMR_A_CTRL3     4'h3
`define TIMR_RESET8      8'h00
// Timing
`define TIMR_STOP_GAP_NS 25
`define TIMR_CLK_NS      8
`define TIMR_SPAN_LSB    16'h4000
// ALU step counts in ALU clock ticks
`define TIMR_CAL_STEPS   5'h10
`define TIMR_MUL_STEPS   5'h18
`endif

/* File: hw/timr_sync.v */
`timescale 1ns/1ps
// Two flip-flop synchroniser for one pin level
module timr_sync
(
    input  wire clk_sys,
    input  wire reset_n,
    input  wire pinIn,
    output reg  pinSync_r
);
    reg stage1_r;

    // First stage is only read by the second
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_r  <= 1'b0;
            pinSync_r <= 1'b0;
        end
        else
        begin
            stage1_r  <= pinIn;
            pinSync_r <= stage1_r;
        end
    end
endmodule // timr_sync

/* File: hw/timr_prealu.v */
`timescale 1ns/1ps
// Pre-ALU: combinational selection and conversion of raw values
module timr_prealu
(
    input  wire [63:0] rawFlat,
    input  wire [2:0]  selA,
    input  wire [2:0]  selB,
    input  wire        halfRes,
    output wire [15:0] valA,
    output wire [15:0] valB
);
    wire [15:0] rawA;
    wire [15:0] rawB;

    // Data selection picks single raw hits; no clock needed
    assign rawA = {1'b0, rawFlat[selA[1:0]*16 +: 15]};
    assign rawB = {1'b0, rawFlat[selB[1:0]*16 +: 15]};
    // Convert to unsigned integer, optional halving for smoother DNL
    assign valA = halfRes ? {1'b0, rawA[15:1]} : rawA;
    assign valB = halfRes ? {1'b0, rawB[15:1]} : rawB;
endmodule // timr_prealu

/* File: verif/timr_seq_props.sv */
`timescale 1ns/1ps
// Register port and regulation flag checks for the sequencer
module timr_seq_props
#(
    parameter FINE_W  = 15,
    parameter ALU_DIV = 8'h04
)
(
    input wire       clk_sys,
    input wire       reset_n,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWr,
    input wire       regRd,
    input wire       pllLocked,
    input wire [7:0] pllProposal,
    input wire [7:0] regRdData_r,
    input wire [7:0] loopAdjust_r,
    input wire       regulatedActive_r
);
    reg regMode_r;
    reg longMode_r;

    // Mode bits as last written; the design may lag these by a cycle
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regMode_r  <= 1'b0;
            longMode_r <= 1'b0;
        end
        else if (regWr && regAddr == 4'h1)
            regMode_r <= regWrData[7];
        else if (regWr && regAddr == 4'h0)
            longMode_r <= regWrData[4];
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_reset_clean: assert property ($rose(reset_n) |-> regRdData_r == 8'h00
        && loopAdjust_r == 8'h00 && !regulatedActive_r) else $error("outputs not clear");
    a_rd_idle: assert property (!regRd |=> regRdData_r == 8'h00)
        else $error("read data without a read");
    a_rd_unmapped: assert property (regRd && regAddr > 4'ha |=> regRdData_r == 8'h00)
        else $error("unmapped read not zero");
    a_rd_proposal: assert property (regRd && regAddr == 4'ha |=>
        regRdData_r == $past(pllProposal)) else $error("proposal read wrong");
    a_loop_take: assert property (regWr && regAddr == 4'ha |=>
        loopAdjust_r == $past(regWrData)) else $error("loop adjust not taken");
    a_loop_hold: assert property (!(regWr && regAddr == 4'ha) [*2] |=>
        $stable(loopAdjust_r)) else $error("loop adjust changed");
    a_lock_drop: assert property (!pllLocked [*2] |-> !regulatedActive_r)
        else $error("regulation kept without lock");
    a_lock_back: assert property ((regMode_r && !longMode_r && pllLocked) [*3] |->
        regulatedActive_r) else $error("regulation not resumed");
    a_long_blocks: assert property (longMode_r [*3] |-> !regulatedActive_r)
        else $error("regulation active in long range");
    a_mode_off: assert property (!regMode_r [*3] |-> !regulatedActive_r)
        else $error("regulation active while mode off");

    c_locked: cover property (regulatedActive_r);
    c_loop_write: cover property (regWr && regAddr == 4'ha);
    c_result_reads: cover property (regRd && regAddr < 4'h8 ##1 regRd);
endmodule // timr_seq_props

bind timr_sequencer timr_seq_props #(.FINE_W(FINE_W), .ALU_DIV(ALU_DIV)) timr_seq_props_inst
(
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .pllLocked(pllLocked), .pllProposal(pllProposal),
    .regRdData_r(regRdData_r), .loopAdjust_r(loopAdjust_r),
    .regulatedActive_r(regulatedActive_r)
);

/* File: verif/timr_pulse_model.sv */
`timescale 1ns/1ps
// Measurement side: free reference clock plus start and stop pulses on request
module timr_pulse_model
#(
    parameter CAL_HALF_NS = 40
)
(
    input  wire clk_sys,
    output reg  calClkPin,
    output reg  startPin,
    output reg  stop1Pin,
    output reg  stop2Pin
);
    // Reference clock never stops; its edges fall on the system negedge
    initial
    begin
        calClkPin = 1'b0;
        startPin = 1'b0;
        stop1Pin = 1'b0;
        stop2Pin = 1'b0;
        forever #(CAL_HALF_NS) calClkPin = ~calClkPin;
    end

    // Pulses are two cycles wide so the synchroniser always sees them
    task pulse(input reg s, input integer gap);
    begin
        @(posedge clk_sys);
        startPin <= !s;
        stop1Pin <= s;
        stop2Pin <= s;
        repeat (2) @(posedge clk_sys);
        {startPin, stop1Pin, stop2Pin} <= 3'b000;
        repeat (gap) @(posedge clk_sys);
    end
    endtask

    task frame(input integer n, input integer gap);
        integer i;
    begin
        pulse(1'b0, 20);
        for (i = 0; i < n; i = i + 1)
            pulse(1'b1, gap);
        repeat (40) @(posedge clk_sys);
    end
    endtask
endmodule // timr_pulse_model

/* File: verif/time_interval_measure_sequencer_tb.sv */
`timescale 1ns/1ps
`include "timr_regs.vh"
// Register level tests of the measurement sequencer
module time_interval_measure_sequencer_tb;
    reg         clk_sys;
    reg         reset_n;
    reg  [3:0]  regAddr;
    reg  [7:0]  regWrData;
    reg         regWr;
    reg         regRd;
    reg         pllLocked;
    reg  [7:0]  pllProposal;
    wire [7:0]  regRdData_r;
    wire [7:0]  loopAdjust_r;
    wire        regulatedActive_r;
    wire        startPin;
    wire        stop1Pin;
    wire        stop2Pin;
    wire        calClkPin;
    reg  [7:0]  d;
    reg  [39:0] rows [0:4];
    integer     nErrors;
    integer     nCompared;
    integer     i;

    timr_sequencer timr_sequencer_inst
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .startPin(startPin), .stop1Pin(stop1Pin),
        .stop2Pin(stop2Pin), .calClkPin(calClkPin), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .pllLocked(pllLocked),
        .pllProposal(pllProposal), .regRdData_r(regRdData_r),
        .loopAdjust_r(loopAdjust_r), .regulatedActive_r(regulatedActive_r)
    );

    timr_pulse_model timr_pulse_model_inst
    (
        .clk_sys(clk_sys), .calClkPin(calClkPin), .startPin(startPin),
        .stop1Pin(stop1Pin), .stop2Pin(stop2Pin)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task cyc(input integer n);
    begin
        repeat (n) @(posedge clk_sys);
        #1;
    end
    endtask

    task wr(input [3:0] a, input [7:0] v);
    begin
        @(posedge clk_sys);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWr <= 1'b0;
    end
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input [3:0] a);
    begin
        @(posedge clk_sys);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdData_r;
    end
    endtask

    task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
        nCompared = nCompared + 1;
        if (seen !== exp)
        begin
            nErrors = nErrors + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask

    // Bounded poll of one status 0 flag; leaves the last status in d
    task waitClear(input integer b);
        integer n;
    begin
        n = 0;
        rd(`TIMR_A_STAT0);
        while (d[b] !== 1'b0 && n < 500)
        begin
            n = n + 1;
            rd(`TIMR_A_STAT0);
        end
        check("busy flag", {7'h00, d[b]}, 8'h00);
    end
    endtask

    task doReset(input integer n);
    begin
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        reset_n <= 1'b1;
    end
    endtask

    task completeRun;
    begin
        $display("compared %0d mismatches %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        nErrors = nErrors + 1;
        completeRun;
    end

    initial
    begin
        nErrors = 0;
        nCompared = 0;
        {reset_n, regWr, regRd, pllLocked} = 4'h0;
        regAddr = 4'h0;
        regWrData = 8'h00;
        pllProposal = 8'h3e;
        // Rows: ctrl0, ctrl1, stop count, gap, expected hits on stop 1 and stop 2
        rows[0] = {8'h10, 8'h00, 8'd6, 8'd40, 8'h40};
        rows[1] = {8'h10, 8'h00, 8'd2, 8'd2, 8'h10};
        rows[2] = {8'h10, 8'h40, 8'd6, 8'd40, 8'h30};
        rows[3] = {8'h00, 8'h40, 8'd6, 8'd12, 8'h40};
        rows[4] = {8'h00, 8'h00, 8'd3, 8'd12, 8'h33};
        doReset(12);
        cyc(1);
        check("loop adjust", loopAdjust_r, 8'h00);
        wr(4'h4, 8'h5a);
        wr(`TIMR_A_MUL0, 8'h3c);
        for (i = 0; i < 8; i = i + 1)
        begin
            rd(i[3:0]);
            check("result byte", d, 8'h00);
        end
        wr(`TIMR_A_LOOPADJ, 8'ha5);
        wr(4'hb, 8'hff);
        cyc(2);
        check("loop adjust", loopAdjust_r, 8'ha5);
        rd(`TIMR_A_PROPOSAL);
        check("proposal", d, 8'h3e);
        rd(4'hc);
        check("unmapped", d, 8'h00);
        wr(`TIMR_A_CTRL1, 8'h80);
        pllLocked <= 1'b1;
        cyc(4);
        check("regulated", {7'h00, regulatedActive_r}, 8'h01);
        rd(`TIMR_A_STAT1);
        check("lock flag", {7'h00, d[7]}, 8'h01);
        pllLocked <= 1'b0;
        cyc(4);
        check("regulated", {7'h00, regulatedActive_r}, 8'h00);
        pllLocked <= 1'b1;
        cyc(4);
        check("regulated", {7'h00, regulatedActive_r}, 8'h01);
        wr(`TIMR_A_CTRL0, 8'h10);
        cyc(4);
        check("regulated", {7'h00, regulatedActive_r}, 8'h00);
        wr(`TIMR_A_CTRL0, 8'h00);
        wr(`TIMR_A_CTRL1, 8'h00);
        // Fastest ALU tick keeps the calibrated run short; the nine pass-through runs use no tick
        wr(`TIMR_A_CTRL6, 8'h10);
        for (i = 1; i < 10; i = i + 1)
        begin
            wr(`TIMR_A_CTRL2, 8'h00);
            waitClear(6);
            check("write index", {5'h00, d[5:3]}, i[7:0] & 8'h07);
        end
        wr(`TIMR_A_CTRL0, 8'hc0);
        wr(`TIMR_A_CTRL2, 8'h00);
        rd(`TIMR_A_STAT0);
        check("cal busy", {7'h00, d[7]}, 8'h01);
        waitClear(7);
        waitClear(6);
        check("write index", {5'h00, d[5:3]}, 8'h03);
        for (i = 0; i < 8; i = i + 1)
            rd(i[3:0]);
        rd(`TIMR_A_STAT0);
        check("write index", {5'h00, d[5:3]}, 8'h03);
        for (i = 0; i < 5; i = i + 1)
        begin
            doReset(2);
            wr(`TIMR_A_CTRL0, rows[i][39:32]);
            wr(`TIMR_A_CTRL1, rows[i][31:24]);
            timr_pulse_model_inst.frame(rows[i][23:16], rows[i][15:8]);
            rd(`TIMR_A_STAT0);
            check("stop 1 hits", {5'h00, d[2:0]}, {4'h0, rows[i][7:4]});
            rd(`TIMR_A_STAT1);
            check("stop 2 hits", {5'h00, d[2:0]}, {4'h0, rows[i][3:0]});
        end
        completeRun;
    end
endmodule // time_interval_measure_sequencer_tb
